//--- rws_pkg.sv
// package for the reset and watchdog sequencer
// assumes a 25 MHz system clock and an AHB-Lite register port
package rws_pkg;
   // ----------------------------------------
   // register map (printed offsets are word indexes)
   // ----------------------------------------
   localparam logic [7:0] REG_IDX_CORE_STATUS = 8'h03;
   localparam logic [7:0] REG_IDX_TIMER_OPTION = 8'h81;
   localparam logic [7:0] REG_IDX_RESET_CAUSE = 8'h8e;
   localparam logic [7:0] REG_IDX_SEQ_CTRL = 8'h40;
   localparam logic [9:0] ADDR_CORE_STATUS = {REG_IDX_CORE_STATUS, 2'b00};
   localparam logic [9:0] ADDR_TIMER_OPTION = {REG_IDX_TIMER_OPTION, 2'b00};
   localparam logic [9:0] ADDR_RESET_CAUSE = {REG_IDX_RESET_CAUSE, 2'b00};
   localparam logic [9:0] ADDR_SEQ_CTRL = {REG_IDX_SEQ_CTRL, 2'b00};
   // ----------------------------------------
   // fields and reset values
   // ----------------------------------------
   localparam int STAT_TIMEOUT_BIT = 4;
   localparam int STAT_POWERDOWN_BIT = 3;
   localparam int OPT_PSA_BIT = 3;
   localparam int POWER_CONTROL_REG_BROWNOUT_BIT = 0;
   localparam int POWER_CONTROL_REG_POWERON_BIT = 1;
   localparam logic [7:0] OPTION_RESET = 8'hff;
   localparam logic [7:0] STATUS_PWR_RESET = 8'h18;
   localparam logic [1:0] BROWNOUT_ENABLE_FIELD_ALWAYS = 2'b11;
   localparam logic [1:0] BROWNOUT_ENABLE_FIELD_RUN_ONLY = 2'b10;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_HZ = 25000000;
   localparam int LFOSC_HZ = 31000;
   localparam int LF_DIV = CLK_HZ / LFOSC_HZ;
   localparam int POWER_UP_DELAY_TIMER_MS = 72;
   localparam int POWER_UP_DELAY_TIMER_BOR_MS = 64;
   localparam int POWER_UP_DELAY_TIMER_TICKS = (POWER_UP_DELAY_TIMER_MS * LFOSC_HZ) / 1000;
   localparam int POWER_UP_DELAY_TIMER_BOR_TICKS = (POWER_UP_DELAY_TIMER_BOR_MS * LFOSC_HZ) / 1000;
   localparam int OST_TICKS = 1024;
   localparam int BOR_FILTER_NS = 2000;
   localparam int BOR_FILTER_CYC = (BOR_FILTER_NS + 39) / 40;
   localparam int WDT_BASE_TICKS = 544;
   typedef enum logic [2:0] {
      SEQ_POR, SEQ_POWER_UP_DELAY_TIMER, SEQ_OST, SEQ_HOLD, SEQ_RUN
   } rws_seq_type;
endpackage : rws_pkg

//--- rws_tick_if.sv
// carrier for the low-frequency tick between divider and sequencer
// assumes one clock shared by both ends
interface rws_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface : rws_tick_if

//--- rws_lf_div.sv
// divider that makes the 31 kHz time-base enable pulse
// assumes the system clock at the rate in the package
module rws_lf_div
   import rws_pkg::*;
#(
   parameter int DIV = LF_DIV
) (
   input wire logic clk,
   input wire logic rst,
   rws_tick_if.src tk
);
   logic [15:0] cnt_r;
   logic wrap;
   assign wrap = (cnt_r == 16'(DIV - 1));
   // free-running count, one pulse per wrap
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 16'h0000;
         tk.tick <= 1'b0;
      end else begin
         cnt_r <= wrap ? 16'h0000 : cnt_r + 16'h0001;
         tk.tick <= wrap;
      end
   end
endmodule : rws_lf_div

//--- rws_sequencer.sv
// reset sequencer, watchdog and reset-cause flags with AHB-Lite registers
// assumes all inputs synchronous to CLK; detector inputs are level pulses
//
// Overview of operation
// - watchdog fuse set keeps the watchdog counting without software
// - watchdog period from prescaler assign bit and three-bit select
// - watchdog cleared when fuse is 0, on clear instruction, on wake
// - brown-out field: 11 always, 10 off in sleep, 0x disabled
// - brown-out resets after detector persists past the filter time
// - brown-out during power-up delay restarts it; 64 ms after recovery
// - power-up delay after power-on pulse, then oscillator start-up unless external clock
// - external clock with delay disable fuse 1 gives no delay
// - delays timed from power-on so late master clear runs at once
// - brown-out reset clears brown-out flag; software sets it
// - brown-out flag is don't-care when field is 00
// - power-on reset clears power-on flag; software writes 1
// - power-up delay only when disable fuse 0; none on wake
// - reset-cause flags per cause as in the cause table
// - status loads 0001 1xxx on power; 000q quuu otherwise
// - power-up delay nominal 72 ms from the slow oscillator
// - watchdog runs from the 31 kHz internal oscillator
// - master clear fuse 0 ignores the pin; 1 uses it active low
module rws_sequencer
   import rws_pkg::*;
#(
   parameter int POWER_UP_DELAY_TIMER_CNT = POWER_UP_DELAY_TIMER_TICKS,
   parameter int POWER_UP_DELAY_TIMER_BOR_CNT = POWER_UP_DELAY_TIMER_BOR_TICKS,
   parameter int OST_CNT = OST_TICKS,
   parameter int WDT_BASE = WDT_BASE_TICKS
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic POR_PULSE,
   input wire logic BOR_DETECT,
   input wire logic MASTER_CLEAR_PIN_N,
   input wire logic FUSE_WDT_EN,
   input wire logic [1:0] FUSE_BROWNOUT_ENABLE_FIELD,
   input wire logic FUSE_POWER_UP_DELAY_TIMER_DIS,
   input wire logic FUSE_MASTER_CLEAR_PIN_EN,
   input wire logic FUSE_EXT_CLK,
   input wire logic SLEEP,
   input wire logic WAKE,
   input wire logic WATCHDOG_CLEAR_INSTR_EXEC,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic CORE_RESET,
   output logic WDT_WAKE
);
   // ----------------------------------------
   // time base
   // ----------------------------------------
   rws_tick_if tk ();
   rws_lf_div u_div (
      .clk(CLK),
      .rst(RST),
      .tk(tk)
   );
   logic lf_tick;
   assign lf_tick = tk.tick;

   // ----------------------------------------
   // registers and state
   // ----------------------------------------
   logic [7:0] status_r;
   logic [7:0] option_r;
   logic [1:0] power_control_reg_r;
   rws_seq_type seq_r;
   rws_seq_type seq_nxt;
   logic [15:0] tmr_r;
   logic [7:0] bor_flt_r;
   logic [22:0] wdt_r;
   logic brst_r;
   logic bor_after_r;
   logic asleep_r;
   logic master_clear_pin_hold;
   logic bor_en;
   logic bor_trip;
   logic wdt_to;
   logic wdt_clr;
   logic [22:0] wdt_limit;
   logic timers_off;
   logic master_clear_pin_evt;
   logic master_clear_pin_d_r;

   // brown-out enable decode and filter
   assign bor_en = (FUSE_BROWNOUT_ENABLE_FIELD == BROWNOUT_ENABLE_FIELD_ALWAYS) ||
                   (FUSE_BROWNOUT_ENABLE_FIELD == BROWNOUT_ENABLE_FIELD_RUN_ONLY && !asleep_r);
   assign bor_trip = bor_en && BOR_DETECT &&
                     (bor_flt_r >= 8'(BOR_FILTER_CYC));
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) bor_flt_r <= 8'h00;
      else if (!(bor_en && BOR_DETECT)) bor_flt_r <= 8'h00;
      else if (bor_flt_r != 8'hff) bor_flt_r <= bor_flt_r + 8'h01;
   end

   // master clear pin only counts when the fuse enables it
   assign master_clear_pin_hold = FUSE_MASTER_CLEAR_PIN_EN && !MASTER_CLEAR_PIN_N;
   assign master_clear_pin_evt = master_clear_pin_hold && !master_clear_pin_d_r;
   // no delays when external clock and power-up delay disabled
   assign timers_off = FUSE_EXT_CLK && FUSE_POWER_UP_DELAY_TIMER_DIS;

   // ----------------------------------------
   // power-up sequence
   // ----------------------------------------
   always_comb begin
      seq_nxt = seq_r;
      unique case (seq_r)
         SEQ_POR: begin
            if (!POR_PULSE && !(bor_en && BOR_DETECT))
               seq_nxt = FUSE_POWER_UP_DELAY_TIMER_DIS ? (timers_off ? SEQ_HOLD : SEQ_OST)
                                        : SEQ_POWER_UP_DELAY_TIMER;
         end
         SEQ_POWER_UP_DELAY_TIMER: begin
            if (lf_tick && tmr_r == 16'h0001)
               seq_nxt = FUSE_EXT_CLK ? SEQ_HOLD : SEQ_OST;
         end
         SEQ_OST: begin
            if (lf_tick && tmr_r == 16'h0001) seq_nxt = SEQ_HOLD;
         end
         SEQ_HOLD: begin
            if (!master_clear_pin_hold) seq_nxt = SEQ_RUN;
         end
         SEQ_RUN: begin
            if (master_clear_pin_hold) seq_nxt = SEQ_HOLD;
         end
      endcase
      if (POR_PULSE) seq_nxt = SEQ_POR;
      else if (bor_trip) seq_nxt = SEQ_POR;
   end

   // delay counter, reloaded on each entry; 64 ms after a brown-out
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         seq_r <= SEQ_POR;
         tmr_r <= 16'h0000;
         bor_after_r <= 1'b0;
         master_clear_pin_d_r <= 1'b0;
      end else begin
         seq_r <= seq_nxt;
         master_clear_pin_d_r <= master_clear_pin_hold;
         if (POR_PULSE) bor_after_r <= 1'b0;
         else if (bor_trip) bor_after_r <= 1'b1;
         if (seq_nxt == SEQ_POWER_UP_DELAY_TIMER && seq_r != SEQ_POWER_UP_DELAY_TIMER)
            tmr_r <= bor_after_r || bor_trip ? 16'(POWER_UP_DELAY_TIMER_BOR_CNT)
                                             : 16'(POWER_UP_DELAY_TIMER_CNT);
         else if (seq_nxt == SEQ_OST && seq_r != SEQ_OST)
            tmr_r <= 16'(OST_CNT);
         else if (lf_tick && tmr_r != 16'h0000)
            tmr_r <= tmr_r - 16'h0001;
      end
   end

   // ----------------------------------------
   // watchdog
   // ----------------------------------------
   // prescaler on the watchdog scales the base period by 2^select
   assign wdt_limit = option_r[OPT_PSA_BIT] ?
                      23'(WDT_BASE) << option_r[2:0] : 23'(WDT_BASE);
   assign wdt_clr = !FUSE_WDT_EN || WATCHDOG_CLEAR_INSTR_EXEC ||
                    (WAKE && asleep_r) || seq_r != SEQ_RUN;
   assign wdt_to = FUSE_WDT_EN && wdt_r >= wdt_limit - 23'h000001;
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) wdt_r <= 23'h000000;
      else if (wdt_clr || (wdt_to && lf_tick)) wdt_r <= 23'h000000;
      else if (lf_tick) wdt_r <= wdt_r + 23'h000001;
   end

   // sleep tracking
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) asleep_r <= 1'b0;
      else if (seq_r != SEQ_RUN || WAKE || (wdt_to && lf_tick)) asleep_r <= 1'b0;
      else if (SLEEP) asleep_r <= 1'b1;
   end

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   logic ph_valid_r;
   logic ph_write_r;
   logic [9:0] ph_addr_r;
   logic take;
   logic wr_status;
   logic wr_option;
   logic wr_power_control_reg;
   assign take = HSEL && HREADY && HTRANS[1];
   assign wr_status = ph_valid_r && ph_write_r && ph_addr_r == ADDR_CORE_STATUS;
   assign wr_option = ph_valid_r && ph_write_r && ph_addr_r == ADDR_TIMER_OPTION;
   assign wr_power_control_reg = ph_valid_r && ph_write_r && ph_addr_r == ADDR_RESET_CAUSE;
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ph_valid_r <= 1'b0;
         ph_write_r <= 1'b0;
         ph_addr_r <= 10'h000;
      end else begin
         ph_valid_r <= take;
         ph_write_r <= HWRITE;
         ph_addr_r <= HADDR[9:0];
      end
   end
   // read data registered on the address phase's edge
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) HRDATA <= 32'h00000000;
      else if (take && !HWRITE) HRDATA <= {24'h000000, rd_mux_a(HADDR[9:0])};
   end
   function automatic logic [7:0] rd_mux_a(input logic [9:0] a);
      rd_mux_a = a == ADDR_CORE_STATUS ? status_r :
                 a == ADDR_TIMER_OPTION ? option_r :
                 a == ADDR_RESET_CAUSE ? {6'h00, power_control_reg_r} :
                 a == ADDR_SEQ_CTRL ? {5'h00, 3'(seq_r)} : 8'h00;
   endfunction : rd_mux_a

   // ----------------------------------------
   // reset-cause and status flags
   // ----------------------------------------
   logic wdt_rst_evt;
   logic wdt_wake_evt;
   assign wdt_rst_evt = wdt_to && lf_tick && !asleep_r && seq_r == SEQ_RUN;
   assign wdt_wake_evt = wdt_to && lf_tick && asleep_r;
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         status_r <= STATUS_PWR_RESET;
         option_r <= OPTION_RESET;
         power_control_reg_r <= 2'b00;
      end else if (POR_PULSE) begin
         status_r <= STATUS_PWR_RESET;
         option_r <= OPTION_RESET;
         power_control_reg_r[POWER_CONTROL_REG_POWERON_BIT] <= 1'b0;
      end else if (bor_trip) begin
         status_r <= STATUS_PWR_RESET;
         option_r <= OPTION_RESET;
         power_control_reg_r <= 2'b10;
      end else if (wdt_rst_evt) begin
         status_r <= {3'b000, 1'b0, status_r[3:0]};
         option_r <= OPTION_RESET;
      end else if (wdt_wake_evt) begin
         status_r[STAT_TIMEOUT_BIT] <= 1'b0;
         status_r[STAT_POWERDOWN_BIT] <= 1'b0;
      end else if (master_clear_pin_evt) begin
         status_r[7:5] <= 3'b000;
         if (asleep_r) status_r[4:3] <= 2'b10;
         option_r <= OPTION_RESET;
      end else begin
         // sleep entry clears the power-down flag in software's view
         if (SLEEP && seq_r == SEQ_RUN) status_r[4:3] <= 2'b10;
         else if (WATCHDOG_CLEAR_INSTR_EXEC) status_r[4:3] <= 2'b11;
         else if (wr_status) status_r <= {HWDATA[7:5], status_r[4:3], HWDATA[2:0]};
         if (wr_option) option_r <= HWDATA[7:0];
         if (wr_power_control_reg) power_control_reg_r <= HWDATA[1:0];
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         brst_r <= 1'b1;
         CORE_RESET <= 1'b1;
         WDT_WAKE <= 1'b0;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else begin
         brst_r <= seq_nxt != SEQ_RUN || wdt_rst_evt;
         CORE_RESET <= brst_r;
         WDT_WAKE <= wdt_wake_evt;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_bor_reset;
      @(posedge CLK) disable iff (RST) bor_trip |=> seq_r == SEQ_POR;
   endproperty
   a_bor_reset: assert property (p_bor_reset) else $error("brown-out not reset");
   property p_bor_flag;
      @(posedge CLK) disable iff (RST) bor_trip && !POR_PULSE |=> power_control_reg_r == 2'b10;
   endproperty
   a_bor_flag: assert property (p_bor_flag) else $error("brown-out flags wrong");
   property p_por_flag;
      @(posedge CLK) disable iff (RST) POR_PULSE |=> !power_control_reg_r[1] && status_r[4:3] == 2'b11;
   endproperty
   a_por_flag: assert property (p_por_flag) else $error("power-on flags wrong");
   property p_brownout_enable_field_off;
      @(posedge CLK) disable iff (RST) !FUSE_BROWNOUT_ENABLE_FIELD[1] |-> !bor_trip;
   endproperty
   a_brownout_enable_field_off: assert property (p_brownout_enable_field_off) else $error("brown-out when off");
   property p_wdt_off;
      @(posedge CLK) disable iff (RST) !FUSE_WDT_EN |=> wdt_r == 23'h000000;
   endproperty
   a_wdt_off: assert property (p_wdt_off) else $error("watchdog not cleared");
   property p_no_delay;
      @(posedge CLK) disable iff (RST)
         seq_r == SEQ_POR && seq_nxt != SEQ_POR && timers_off |=> seq_r == SEQ_HOLD;
   endproperty
   a_no_delay: assert property (p_no_delay) else $error("delay inserted");
   property p_order;
      @(posedge CLK) disable iff (RST) seq_r == SEQ_OST |-> $past(seq_r) != SEQ_HOLD;
   endproperty
   a_order: assert property (p_order) else $error("start-up out of order");
   property p_release;
      @(posedge CLK) disable iff (RST) seq_r == SEQ_HOLD && !master_clear_pin_hold && !POR_PULSE
         && !bor_trip |-> ##2 !CORE_RESET;
   endproperty
   a_release: assert property (p_release) else $error("release late");
   c_bor: cover property (@(posedge CLK) disable iff (RST) bor_trip);
   c_wdt: cover property (@(posedge CLK) disable iff (RST) wdt_rst_evt);
   c_run: cover property (@(posedge CLK) disable iff (RST) seq_r == SEQ_RUN);
endmodule : rws_sequencer

//--- test_rws_sequencer.sv
// self-checking testbench for the reset and watchdog sequencer
// assumes the package and design files are compiled first; the bus answers at once
module test_rws_sequencer
   import rws_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // shortened counts and bench signals
   // ----------------------------------------
   localparam int PW = 4;
   localparam int PB = 3;
   localparam int OC = 4;
   localparam int WB = 4;
   localparam logic [31:0] TO_M = 32'h1 << STAT_TIMEOUT_BIT;
   localparam logic [31:0] PD_M = 32'h1 << STAT_POWERDOWN_BIT;
   localparam logic [31:0] TP = TO_M | PD_M;
   logic CLK, RST, POR_PULSE, BOR_DETECT, MASTER_CLEAR_PIN_N, FUSE_WDT_EN, FUSE_POWER_UP_DELAY_TIMER_DIS;
   logic FUSE_MASTER_CLEAR_PIN_EN, FUSE_EXT_CLK, SLEEP, WAKE, WATCHDOG_CLEAR_INSTR_EXEC, HSEL, HWRITE;
   logic HREADYOUT, HRESP, CORE_RESET, WDT_WAKE;
   logic [1:0] FUSE_BROWNOUT_ENABLE_FIELD, HTRANS;
   logic [2:0] HSIZE;
   logic [31:0] HADDR, HWDATA, HRDATA, rd_data;
   int errors, check_count, n;

   // 25 MHz clock
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end

   // single slave, so its ready is the bus ready
   rws_sequencer #(.POWER_UP_DELAY_TIMER_CNT(PW), .POWER_UP_DELAY_TIMER_BOR_CNT(PB), .OST_CNT(OC), .WDT_BASE(WB)) dut (
      .CLK(CLK), .RST(RST), .POR_PULSE(POR_PULSE), .BOR_DETECT(BOR_DETECT),
      .MASTER_CLEAR_PIN_N(MASTER_CLEAR_PIN_N), .FUSE_WDT_EN(FUSE_WDT_EN), .FUSE_BROWNOUT_ENABLE_FIELD(FUSE_BROWNOUT_ENABLE_FIELD),
      .FUSE_POWER_UP_DELAY_TIMER_DIS(FUSE_POWER_UP_DELAY_TIMER_DIS), .FUSE_MASTER_CLEAR_PIN_EN(FUSE_MASTER_CLEAR_PIN_EN),
      .FUSE_EXT_CLK(FUSE_EXT_CLK), .SLEEP(SLEEP), .WAKE(WAKE), .WATCHDOG_CLEAR_INSTR_EXEC(WATCHDOG_CLEAR_INSTR_EXEC),
      .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
      .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
      .HRESP(HRESP), .CORE_RESET(CORE_RESET), .WDT_WAKE(WDT_WAKE));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // address phase held until ready, then data phase held until ready
   task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
      @(posedge CLK);
      HSEL <= 1'b1;
      HTRANS <= 2'b10;
      HADDR <= {22'h0, a};
      HWRITE <= wr;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'b00;
      HWDATA <= d;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      rd_data = HRDATA;
   endtask : bus

   task automatic rd(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd_data & m, e);
   endtask : rd

   task automatic hold(input int c);
      repeat (c) @(posedge CLK);
   endtask : hold

   // bounded wait; n keeps the cycles spent for timing checks
   task automatic wait_for(input logic wk, input logic lvl, input int max);
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while ((wk ? WDT_WAKE : CORE_RESET) !== lvl && n < max);
      chk({31'h0, n < max}, 32'h1);
   endtask : wait_for

   task automatic power_on(input int c);
      POR_PULSE <= 1'b1;
      hold(c);
      POR_PULSE <= 1'b0;
   endtask : power_on

   task automatic brown(input int c);
      BOR_DETECT <= 1'b1;
      hold(c);
      BOR_DETECT <= 1'b0;
   endtask : brown

   // 0 sleep, 1 wake, 2 watchdog clear; one-cycle pulses
   task automatic strobe(input int w);
      @(posedge CLK);
      SLEEP <= (w == 0);
      WAKE <= (w == 1);
      WATCHDOG_CLEAR_INSTR_EXEC <= (w == 2);
      @(posedge CLK);
      SLEEP <= 1'b0;
      WAKE <= 1'b0;
      WATCHDOG_CLEAR_INSTR_EXEC <= 1'b0;
   endtask : strobe

   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report

   // hang guard, well beyond the roughly 34k cycles the tests need
   initial begin
      #3600000;
      errors++;
      final_report();
   end

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      RST = 1'b1;
      POR_PULSE = 1'b1;
      BOR_DETECT = 1'b0;
      MASTER_CLEAR_PIN_N = 1'b1;
      FUSE_WDT_EN = 1'b0;
      FUSE_BROWNOUT_ENABLE_FIELD = BROWNOUT_ENABLE_FIELD_ALWAYS;
      FUSE_POWER_UP_DELAY_TIMER_DIS = 1'b0;
      FUSE_MASTER_CLEAR_PIN_EN = 1'b1;
      FUSE_EXT_CLK = 1'b0;
      SLEEP = 1'b0;
      WAKE = 1'b0;
      WATCHDOG_CLEAR_INSTR_EXEC = 1'b0;
      HSEL = 1'b0;
      HADDR = 32'h0;
      HTRANS = 2'b00;
      HWRITE = 1'b0;
      HSIZE = 3'b010;
      HWDATA = 32'h0;
      errors = 0;
      check_count = 0;
      n = 0;
      hold(12);
      RST <= 1'b0;
      // power-up delay only starts once the detector pulse ends
      hold(20);
      chk({31'h0, CORE_RESET}, 32'h1);
      POR_PULSE <= 1'b0;
      hold(100);
      chk({31'h0, CORE_RESET}, 32'h1);
      wait_for(1'b0, 1'b0, 20000);
      chk({31'h0, n + 100 >= (PW - 1) * LF_DIV}, 32'h1);
      rd(ADDR_CORE_STATUS, TP, TP);
      rd(ADDR_RESET_CAUSE, 32'h2, 32'h0);
      rd(ADDR_TIMER_OPTION, 32'hffffffff, {24'h0, OPTION_RESET});
      rd(10'h3f0, 32'hffffffff, 32'h0);
      chk({31'h0, HRESP}, 32'h0);
      bus(1'b1, ADDR_RESET_CAUSE, 32'h3);
      rd(ADDR_RESET_CAUSE, 32'h3, 32'h3);
      // second brown-out in mid delay must restart the delay
      brown(BOR_FILTER_CYC + 20);
      chk({31'h0, CORE_RESET}, 32'h1);
      hold(1000);
      brown(BOR_FILTER_CYC + 20);
      wait_for(1'b0, 1'b0, 20000);
      chk({31'h0, n >= (PB - 1) * LF_DIV}, 32'h1);
      rd(ADDR_RESET_CAUSE, 32'h3, 32'h2);
      rd(ADDR_CORE_STATUS, TP, TP);
      // brown-out ignored when disabled, or run-only while asleep
      for (int i = 0; i < 3; i++) begin
         hold(1);
         FUSE_BROWNOUT_ENABLE_FIELD <= (i == 2) ? BROWNOUT_ENABLE_FIELD_RUN_ONLY : i[1:0];
         if (i == 2) strobe(0);
         brown(BOR_FILTER_CYC + 50);
         chk({31'h0, CORE_RESET}, 32'h0);
      end
      strobe(1);
      FUSE_BROWNOUT_ENABLE_FIELD <= BROWNOUT_ENABLE_FIELD_ALWAYS;
      // pin has no effect while its fuse is clear
      FUSE_MASTER_CLEAR_PIN_EN <= 1'b0;
      MASTER_CLEAR_PIN_N <= 1'b0;
      hold(50);
      chk({31'h0, CORE_RESET}, 32'h0);
      MASTER_CLEAR_PIN_N <= 1'b1;
      FUSE_MASTER_CLEAR_PIN_EN <= 1'b1;
      // the earlier sleep left power-down clear; clear instruction sets both flags
      strobe(2);
      // master clear while running, then while asleep
      for (int i = 0; i < 2; i++) begin
         if (i == 1) strobe(0);
         hold(1);
         MASTER_CLEAR_PIN_N <= 1'b0;
         hold(50);
         chk({31'h0, CORE_RESET}, 32'h1);
         MASTER_CLEAR_PIN_N <= 1'b1;
         wait_for(1'b0, 1'b0, 50);
         rd(ADDR_CORE_STATUS, TP, (i == 1) ? TO_M : TP);
         rd(ADDR_RESET_CAUSE, 32'h3, 32'h2);
      end
      // clear instruction holds the watchdog off, then it expires
      bus(1'b1, ADDR_TIMER_OPTION, 32'h0);
      rd(ADDR_TIMER_OPTION, 32'hff, 32'h0);
      FUSE_WDT_EN <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         hold(1000);
         strobe(2);
         chk({31'h0, CORE_RESET}, 32'h0);
      end
      wait_for(1'b0, 1'b1, 20000);
      chk({31'h0, n >= (WB - 1) * LF_DIV}, 32'h1);
      wait_for(1'b0, 1'b0, 20000);
      rd(ADDR_CORE_STATUS, TP, PD_M);
      rd(ADDR_TIMER_OPTION, 32'hff, {24'h0, OPTION_RESET});
      // prescaler doubles the period; expiry in sleep wakes without reset
      bus(1'b1, ADDR_TIMER_OPTION, (32'h1 << OPT_PSA_BIT) | 32'h1);
      strobe(2);
      strobe(0);
      wait_for(1'b1, 1'b1, 30000);
      chk({31'h0, n >= (2 * WB - 1) * LF_DIV}, 32'h1);
      chk({31'h0, CORE_RESET}, 32'h0);
      rd(ADDR_CORE_STATUS, TP, 32'h0);
      FUSE_WDT_EN <= 1'b0;
      // external clock: no delay when disabled, full delay otherwise
      FUSE_EXT_CLK <= 1'b1;
      FUSE_POWER_UP_DELAY_TIMER_DIS <= 1'b1;
      power_on(20);
      wait_for(1'b0, 1'b0, 8);
      rd(ADDR_RESET_CAUSE, 32'h2, 32'h0);
      rd(ADDR_CORE_STATUS, TP, TP);
      FUSE_POWER_UP_DELAY_TIMER_DIS <= 1'b0;
      power_on(20);
      hold(100);
      chk({31'h0, CORE_RESET}, 32'h1);
      wait_for(1'b0, 1'b0, 20000);
      rd(ADDR_SEQ_CTRL, 32'h7, 32'(SEQ_RUN));
      final_report();
   end
endmodule : test_rws_sequencer
